// [verilog/uio_pkg.sv]
// constants and types for the user i/o digital function block
package uio_pkg;
  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [5:0] OFS_DIN_MAP = 6'h00;
  localparam logic [5:0] OFS_DOUT_MAP = 6'h04;
  localparam logic [5:0] OFS_CTRL = 6'h08;
  localparam logic [5:0] OFS_STATUS = 6'h0c;
  localparam logic [5:0] OFS_IRQ_STAT = 6'h10;
  localparam logic [5:0] OFS_IRQ_MASK = 6'h14;
  // ****************************************
  // field layouts and reset values
  // ****************************************
  localparam int NUM_DIN = 4;
  localparam int NUM_DOUT = 8;
  localparam int DIN_FW = 3;
  localparam int DOUT_FW = 4;
  localparam int QCNT_W = 19;
  localparam logic [11:0] DIN_MAP_RST = 12'h001;
  localparam logic [31:0] DOUT_MAP_RST = 32'h0000_0431;
  localparam int CTRL_START = 0;
  localparam int CTRL_STOP = 1;
  localparam int CTRL_CLEAR = 2;
  localparam int IRQ_W = 4;
  localparam int IRQ_START = 0;
  localparam int IRQ_STOP = 1;
  localparam int IRQ_ILK = 2;
  localparam int IRQ_FAULT = 3;
  // ****************************************
  // input functions and output state flags
  // ****************************************
  localparam logic [2:0] FN_NONE = 3'h0;
  localparam logic [2:0] FN_ENABLE = 3'h1;
  localparam logic [2:0] FN_ILOCK = 3'h2;
  localparam logic [2:0] FN_CLEAR = 3'h3;
  localparam logic [2:0] FN_KLOCK = 3'h4;
  localparam logic [2:0] FN_START = 3'h5;
  localparam logic [2:0] FN_STOP = 3'h6;
  localparam int NUM_FL = 10;
  localparam logic [3:0] FL_NONE = 4'h0;
  localparam logic [3:0] FL_ENABLED = 4'h1;
  localparam logic [3:0] FL_SBY_FLT = 4'h2;
  localparam logic [3:0] FL_SBY = 4'h3;
  localparam logic [3:0] FL_FAULT = 4'h4;
  localparam logic [3:0] FL_CV = 4'h5;
  localparam logic [3:0] FL_CC = 4'h6;
  localparam logic [3:0] FL_CP = 4'h7;
  localparam logic [3:0] FL_CR = 4'h8;
  localparam logic [3:0] FL_LOCK = 4'h9;
  localparam logic [1:0] MODE_CV = 2'h0;
  localparam logic [1:0] MODE_CC = 2'h1;
  localparam logic [1:0] MODE_CP = 2'h2;
  localparam logic [1:0] MODE_CR = 2'h3;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_HZ = 125_000_000;
  localparam int QUAL_MS = 3;
  localparam int QUAL_CYC_DEF = QUAL_MS * (CLK_HZ / 1000);
  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic [5:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } uio_avs_req_t;
  typedef struct packed {
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] filt;
    logic [3:0][18:0] qcnt;
    logic [11:0] din_map;
    logic [31:0] dout_map;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic run;
    logic fault;
    logic ilk;
    logic locked;
    logic key;
    logic irq;
    logic waitreq;
    logic [31:0] rdata;
    logic [7:0] dout;
  } uio_state_t;
endpackage

// [verilog/uio_top.sv]
// user i/o digital inputs and outputs with avalon-mm register access
// Summary of operation
// - four digital inputs each take one selectable function or none.
// - momentary functions fire on a rising edge held high at least 3 ms.
// - a normally-closed function fires once the high level is removed.
// - an active-when-present function holds exactly while the input is high.
// - stop wins over start when both are requested.
// - input enable is a level: processing while high, stopped while low.
// - interlock is normally closed and trips when the high level goes away.
// - fault clear removes the fault only if the fault is gone; else it stays.
// - while keypad lock is asserted front panel key presses are dropped.
// - eight digital outputs each take one selectable state flag or none.
// - an assigned output is high while its state is active, else low.
// - the enabled flag is input engaged and unit processing.
// - the standby-or-fault flag is the or of standby and fault.
// - separate flags show standby alone and fault alone.
// - four flags show the active cv, cc, cp or cr loop.
// - the lock flag shows the keypad lock engaged.
//
// The register offsets and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module uio_top #(
  parameter int QUAL_CYC = uio_pkg::QUAL_CYC_DEF
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire uio_pkg::uio_avs_req_t avs_req_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic [3:0] din_in,
  input wire logic fault_cond_in,
  input wire logic engaged_in,
  input wire logic [1:0] reg_mode_in,
  input wire logic key_press_in,
  output logic [7:0] dout_out,
  output logic run_out,
  output logic key_press_out,
  output logic irq_out
);
  localparam logic [18:0] QMAX = 19'(QUAL_CYC - 1);

  uio_pkg::uio_state_t st_reg;
  uio_pkg::uio_state_t st_next;
  logic [3:0] rise;
  logic en_asg;
  logic en_lvl;
  logic ilk_bad;
  logic clr_any;
  logic lock_lvl;
  logic start_ev;
  logic stop_ev;
  logic start_any;
  logic stop_any;
  logic wr;
  logic [2:0] sw_cmd;
  logic [3:0] w1c;
  logic [3:0] ev;
  logic [9:0] flags;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [2:0] fn;
    logic [3:0] fl;
    fn = uio_pkg::FN_NONE;
    fl = uio_pkg::FL_NONE;
    st_next = st_reg;
    rise = '0;
    en_asg = 1'b0;
    en_lvl = 1'b0;
    ilk_bad = 1'b0;
    clr_any = 1'b0;
    lock_lvl = 1'b0;
    start_ev = 1'b0;
    stop_ev = 1'b0;
    sw_cmd = '0;
    w1c = '0;

    // bus: ack one cycle after request, write acts at completion edge
    st_next.waitreq = 1'b1;
    wr = !st_reg.waitreq && avs_req_in.write;
    if (st_reg.waitreq && (avs_req_in.read || avs_req_in.write)) begin
      st_next.waitreq = 1'b0;
      unique case (avs_req_in.address)
        uio_pkg::OFS_DIN_MAP: st_next.rdata = {20'h0, st_reg.din_map};
        uio_pkg::OFS_DOUT_MAP: st_next.rdata = st_reg.dout_map;
        uio_pkg::OFS_STATUS: begin
          st_next.rdata = {24'h0, st_reg.filt, st_reg.locked,
                           st_reg.ilk, st_reg.fault, st_reg.run};
        end
        uio_pkg::OFS_IRQ_STAT: st_next.rdata = {28'h0, st_reg.irq_stat};
        uio_pkg::OFS_IRQ_MASK: st_next.rdata = {28'h0, st_reg.irq_mask};
        default: st_next.rdata = 32'h0;
      endcase
    end
    if (wr) begin
      unique case (avs_req_in.address)
        uio_pkg::OFS_DIN_MAP: st_next.din_map = avs_req_in.writedata[11:0];
        uio_pkg::OFS_DOUT_MAP: st_next.dout_map = avs_req_in.writedata;
        uio_pkg::OFS_CTRL: sw_cmd = avs_req_in.writedata[2:0];
        uio_pkg::OFS_IRQ_STAT: w1c = avs_req_in.writedata[3:0];
        uio_pkg::OFS_IRQ_MASK: st_next.irq_mask = avs_req_in.writedata[3:0];
        default: ;
      endcase
    end

    // input qualification
    st_next.sync1 = din_in;
    st_next.sync2 = st_reg.sync1;
    for (int i = 0; i < uio_pkg::NUM_DIN; i++) begin
      if (st_reg.sync2[i] == st_reg.filt[i]) begin
        st_next.qcnt[i] = '0;
      end else if (st_reg.qcnt[i] == QMAX) begin
        st_next.filt[i] = st_reg.sync2[i];
        st_next.qcnt[i] = '0;
      end else begin
        st_next.qcnt[i] = st_reg.qcnt[i] + 19'h1;
      end
    end
    rise = st_next.filt & ~st_reg.filt;

    // function per input pin
    for (int i = 0; i < uio_pkg::NUM_DIN; i++) begin
      fn = st_reg.din_map[i*uio_pkg::DIN_FW +: uio_pkg::DIN_FW];
      unique case (fn)
        uio_pkg::FN_NONE: ;
        uio_pkg::FN_ENABLE: begin
          en_asg = 1'b1;
          en_lvl = en_lvl | st_next.filt[i];
        end
        uio_pkg::FN_ILOCK: ilk_bad = ilk_bad | !st_next.filt[i];
        uio_pkg::FN_CLEAR: clr_any = clr_any | st_next.filt[i];
        uio_pkg::FN_KLOCK: lock_lvl = lock_lvl | st_next.filt[i];
        uio_pkg::FN_START: start_ev = start_ev | rise[i];
        uio_pkg::FN_STOP: stop_ev = stop_ev | rise[i];
        default: ;
      endcase
    end
    clr_any = clr_any | sw_cmd[uio_pkg::CTRL_CLEAR];

    // interlock and fault latches
    if (ilk_bad) begin
      st_next.ilk = 1'b1;
    end else if (clr_any) begin
      st_next.ilk = 1'b0;
    end
    if (fault_cond_in || ilk_bad) begin
      st_next.fault = 1'b1;
    end else if (clr_any) begin
      st_next.fault = 1'b0;
    end

    // run control, stop first
    stop_any = stop_ev | sw_cmd[uio_pkg::CTRL_STOP] | st_next.fault
      | (en_asg & !en_lvl);
    start_any = start_ev | sw_cmd[uio_pkg::CTRL_START] | (en_asg & en_lvl);
    if (stop_any) begin
      st_next.run = 1'b0;
    end else if (start_any) begin
      st_next.run = 1'b1;
    end

    // keypad lock
    st_next.locked = lock_lvl;
    st_next.key = key_press_in & !lock_lvl;

    // interrupts, set beats clear
    ev = '0;
    ev[uio_pkg::IRQ_START] = st_next.run & !st_reg.run;
    ev[uio_pkg::IRQ_STOP] = !st_next.run & st_reg.run;
    ev[uio_pkg::IRQ_ILK] = st_next.ilk & !st_reg.ilk;
    ev[uio_pkg::IRQ_FAULT] = st_next.fault & !st_reg.fault;
    st_next.irq_stat = (st_reg.irq_stat & ~w1c) | ev;
    st_next.irq = |(st_next.irq_stat & st_next.irq_mask);

    // state flags
    flags = '0;
    flags[uio_pkg::FL_ENABLED] = engaged_in & st_next.run;
    flags[uio_pkg::FL_SBY] = !st_next.run;
    flags[uio_pkg::FL_FAULT] = st_next.fault;
    flags[uio_pkg::FL_SBY_FLT] = !st_next.run | st_next.fault;
    flags[uio_pkg::FL_CV] = st_next.run & (reg_mode_in == uio_pkg::MODE_CV);
    flags[uio_pkg::FL_CC] = st_next.run & (reg_mode_in == uio_pkg::MODE_CC);
    flags[uio_pkg::FL_CP] = st_next.run & (reg_mode_in == uio_pkg::MODE_CP);
    flags[uio_pkg::FL_CR] = st_next.run & (reg_mode_in == uio_pkg::MODE_CR);
    flags[uio_pkg::FL_LOCK] = lock_lvl;
    for (int j = 0; j < uio_pkg::NUM_DOUT; j++) begin
      fl = st_reg.dout_map[j*uio_pkg::DOUT_FW +: uio_pkg::DOUT_FW];
      if (fl == uio_pkg::FL_NONE || fl > uio_pkg::FL_LOCK) begin
        st_next.dout[j] = 1'b0;
      end else begin
        st_next.dout[j] = flags[fl];
      end
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_reg <= '0;
      st_reg.din_map <= uio_pkg::DIN_MAP_RST;
      st_reg.dout_map <= uio_pkg::DOUT_MAP_RST;
      st_reg.waitreq <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign avs_readdata_out = st_reg.rdata;
  assign avs_waitrequest_out = st_reg.waitreq;
  assign dout_out = st_reg.dout;
  assign run_out = st_reg.run;
  assign key_press_out = st_reg.key;
  assign irq_out = st_reg.irq;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  chk_stop_wins: assert property (
    (stop_ev && start_ev) |=> !run_out)
    else $error("start won over stop");
  chk_enable_level: assert property (
    (en_asg && en_lvl && !stop_any) |=> run_out)
    else $error("input enable high did not run");
  chk_enable_low: assert property (
    (en_asg && !en_lvl) |=> !run_out)
    else $error("input enable low did not stop");
  chk_sby_flag: assert property (
    (st_reg.dout_map[7:4] == uio_pkg::FL_SBY) |=> dout_out[1] == !run_out)
    else $error("standby flag wrong");
  chk_sbyflt_flag: assert property (
    (st_reg.dout_map[11:8] == uio_pkg::FL_SBY_FLT)
    |=> dout_out[2] == (!run_out || st_reg.fault))
    else $error("standby or fault flag wrong");
  chk_enabled_flag: assert property (
    (st_reg.dout_map[3:0] == uio_pkg::FL_ENABLED)
    |=> dout_out[0] == (run_out && $past(engaged_in)))
    else $error("enabled flag wrong");
  chk_cv_flag: assert property (
    (st_reg.dout_map[19:16] == uio_pkg::FL_CV)
    |=> dout_out[4] == (run_out && $past(reg_mode_in) == uio_pkg::MODE_CV))
    else $error("cv flag wrong");
  chk_lock_flag: assert property (
    (st_reg.dout_map[3:0] == uio_pkg::FL_LOCK) |=> dout_out[0] == st_reg.locked)
    else $error("lock flag wrong");
  chk_unused_out: assert property (
    (st_reg.dout_map[31:28] == uio_pkg::FL_NONE) |=> !dout_out[7])
    else $error("unassigned output driven high");
  chk_mask_write: assert property (
    (!avs_waitrequest_out && avs_req_in.write
      && avs_req_in.address == uio_pkg::OFS_IRQ_MASK)
    |=> st_reg.irq_mask == $past(avs_req_in.writedata[3:0]))
    else $error("mask write lost");
  chk_rdata_hold: assert property (
    (avs_waitrequest_out && !avs_req_in.read && !avs_req_in.write)
    |=> $stable(avs_readdata_out))
    else $error("read data moved while idle");
  chk_event_sets: assert property (
    (ev != 4'h0) |=> (st_reg.irq_stat & $past(ev)) == $past(ev))
    else $error("event lost against clear");
  chk_ilock_trip: assert property (
    ilk_bad |=> (st_reg.ilk && st_reg.fault && !run_out))
    else $error("interlock did not trip");
  chk_fault_held: assert property (
    (st_reg.fault && fault_cond_in) |=> st_reg.fault)
    else $error("persisting fault was cleared");
  chk_fault_clear: assert property (
    (st_reg.fault && clr_any && !fault_cond_in && !ilk_bad) |=> !st_reg.fault)
    else $error("fault clear ignored");
  chk_key_block: assert property (
    lock_lvl |=> !key_press_out)
    else $error("key press passed while locked");
  chk_start_edge: assert property (
    (start_ev && !stop_any) |=> run_out)
    else $error("momentary start missed");
  chk_dout_fault: assert property (
    (st_reg.dout_map[3:0] == uio_pkg::FL_FAULT) |=> dout_out[0] == st_reg.fault)
    else $error("output does not follow fault");
  chk_qual_hold: assert property (
    $changed(st_reg.filt[0]) |-> $past(st_reg.qcnt[0]) == QMAX
      && st_reg.filt[0] == $past(st_reg.sync2[0]))
    else $error("input changed before qualification");
  chk_irq_level: assert property (
    irq_out == |(st_reg.irq_stat & st_reg.irq_mask))
    else $error("interrupt level mismatch");
  chk_bus_ack: assert property (
    (avs_waitrequest_out && (avs_req_in.read || avs_req_in.write))
    |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
    else $error("bus ack not one cycle");

  cov_run_start: cover property ($rose(run_out));
  cov_ilock_trip: cover property ($rose(st_reg.ilk));
  cov_fault_clear: cover property ($fell(st_reg.fault));
  cov_key_lock: cover property (key_press_in && lock_lvl);
endmodule

// [bench/uio_contacts.sv]
// dry contact model driving the four digital input pins
`timescale 1ns/1ps
module uio_contacts #(
  parameter int HOLD = 8
) (
  input wire logic clk_in,
  input wire logic [3:0] want_in,
  input wire logic [3:0] glitch_in,
  output logic [3:0] din_out
);
  logic [3:0] level_reg = 4'h0;
  int cnt [4] = '{default: 0};
  // a contact moves only after holding its level for HOLD cycles
  always @(posedge clk_in) begin
    for (int i = 0; i < 4; i++) begin
      if (want_in[i] != level_reg[i] && cnt[i] >= HOLD) begin
        level_reg[i] <= want_in[i];
        cnt[i] <= 0;
      end else if (cnt[i] < HOLD) begin
        cnt[i] <= cnt[i] + 1;
      end
    end
  end
  // bounce injected only when the bench asks for it
  assign din_out = level_reg ^ glitch_in;
endmodule

// [bench/uio_top_tb_top.sv]
// self-checking testbench for the user i/o digital function block
`timescale 1ns/1ps
module uio_top_tb_top;
  typedef struct packed {
    logic [1:0] mode;
    logic eng;
    logic [7:0] exp;
  } uio_row_t;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  uio_pkg::uio_avs_req_t avs_req = '0;
  logic [31:0] rdata;
  logic wreq;
  logic [3:0] want = 4'h0;
  logic [3:0] glitch = 4'h0;
  logic [3:0] din;
  logic fault_cond = 1'b0;
  logic engaged = 1'b1;
  logic [1:0] mode = 2'h0;
  logic key_in = 1'b0;
  logic [7:0] dout;
  logic run;
  logic key_out;
  logic irq;
  logic [31:0] q;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  uio_row_t rows [5] = '{'{2'h0, 1'b1, 8'h11}, '{2'h1, 1'b1, 8'h21},
    '{2'h2, 1'b1, 8'h41}, '{2'h3, 1'b1, 8'h81}, '{2'h0, 1'b0, 8'h10}};
  uio_top #(
    .QUAL_CYC(8)
  ) dut (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .avs_req_in(avs_req),
    .avs_readdata_out(rdata),
    .avs_waitrequest_out(wreq),
    .din_in(din),
    .fault_cond_in(fault_cond),
    .engaged_in(engaged),
    .reg_mode_in(mode),
    .key_press_in(key_in),
    .dout_out(dout),
    .run_out(run),
    .key_press_out(key_out),
    .irq_out(irq)
  );
  uio_contacts #(
    .HOLD(8)
  ) contacts (
    .clk_in(clk_in),
    .want_in(want),
    .glitch_in(glitch),
    .din_out(din)
  );
  // ****************************************
  // helpers
  // ****************************************
  initial begin
    forever #4 clk_in = ~clk_in;
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic [5:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    avs_req <= '{address: a, read: !w, write: w, writedata: d};
    // look at waitrequest mid-cycle, complete at the following rising edge
    do begin
      @(negedge clk_in);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    if (n >= 50) mismatches++;
    @(posedge clk_in);
    q = rdata;
    avs_req.read <= 1'b0;
    avs_req.write <= 1'b0;
  endtask
  task automatic rdchk(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e,
      input string name);
    bus(a, 1'b0, 32'h0);
    chk(name, e, q & m);
  endtask
  task automatic settle;
    repeat (30) @(posedge clk_in);
  endtask
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    chk("dout_rst", 32'h2, 32'(dout));
    rdchk(uio_pkg::OFS_DIN_MAP, '1, 32'h1, "din_map");
    rdchk(uio_pkg::OFS_DOUT_MAP, '1, 32'h431, "dout_map");
    rdchk(uio_pkg::OFS_IRQ_MASK, '1, 32'h0, "irq_mask");
    rdchk(6'h3c, '1, 32'h0, "unmapped");
    bus(uio_pkg::OFS_DOUT_MAP, 1'b1, 32'h8765_4321);
    want <= 4'h1;
    settle();
    chk("run_en", 32'h1, 32'(run));
    foreach (rows[i]) begin
      mode <= rows[i].mode;
      engaged <= rows[i].eng;
      repeat (3) @(posedge clk_in);
      chk("dout_row", 32'(rows[i].exp), 32'(dout));
    end
    engaged <= 1'b1;
    want <= 4'h0;
    settle();
    chk("sby_flags", 32'h6, 32'(dout[2:0]));
    // start, stop and lock pins
    bus(uio_pkg::OFS_DIN_MAP, 1'b1, 32'h9a8);
    want <= 4'h6;
    settle();
    want <= 4'h0;
    settle();
    chk("run_both", 32'h0, 32'(run));
    bus(uio_pkg::OFS_IRQ_MASK, 1'b1, 32'h1);
    want <= 4'h2;
    settle();
    want <= 4'h0;
    settle();
    chk("run_start", 32'h1, 32'(run));
    chk("irq_on", 32'h1, 32'(irq));
    bus(uio_pkg::OFS_IRQ_STAT, 1'b1, 32'h1);
    repeat (2) @(posedge clk_in);
    chk("irq_off", 32'h0, 32'(irq));
    glitch <= 4'h4;
    repeat (3) @(posedge clk_in);
    glitch <= 4'h0;
    settle();
    chk("run_glitch", 32'h1, 32'(run));
    want <= 4'h4;
    settle();
    chk("run_stop", 32'h0, 32'(run));
    want <= 4'h0;
    bus(uio_pkg::OFS_CTRL, 1'b1, 32'h3);
    rdchk(uio_pkg::OFS_STATUS, 32'h1, 32'h0, "ctrl_both");
    bus(uio_pkg::OFS_CTRL, 1'b1, 32'h1);
    rdchk(uio_pkg::OFS_STATUS, 32'h1, 32'h1, "ctrl_start");
    bus(uio_pkg::OFS_CTRL, 1'b1, 32'h2);
    rdchk(uio_pkg::OFS_STATUS, 32'h1, 32'h0, "ctrl_stop");
    bus(uio_pkg::OFS_DOUT_MAP, 1'b1, 32'h9);
    want <= 4'h8;
    settle();
    chk("lock_flag", 32'h1, 32'(dout[0]));
    key_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    chk("key_locked", 32'h0, 32'(key_out));
    key_in <= 1'b0;
    want <= 4'h0;
    settle();
    key_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    chk("key_free", 32'h1, 32'(key_out));
    key_in <= 1'b0;
    // interlock and fault clear
    want <= 4'h1;
    settle();
    bus(uio_pkg::OFS_DIN_MAP, 1'b1, 32'h1a);
    bus(uio_pkg::OFS_DOUT_MAP, 1'b1, 32'h4);
    want <= 4'h0;
    settle();
    rdchk(uio_pkg::OFS_STATUS, 32'h6, 32'h6, "ilk_trip");
    fault_cond <= 1'b1;
    want <= 4'h1;
    settle();
    want <= 4'h3;
    settle();
    rdchk(uio_pkg::OFS_STATUS, 32'h2, 32'h2, "fault_held");
    chk("fault_out", 32'h1, 32'(dout[0]));
    want <= 4'h1;
    fault_cond <= 1'b0;
    settle();
    want <= 4'h3;
    settle();
    rdchk(uio_pkg::OFS_STATUS, 32'h6, 32'h0, "fault_clr");
    // reset mid-test while stopped, maps rewritten
    want <= 4'h0;
    rst_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    chk("dout_rst2", 32'h2, 32'(dout));
    rdchk(uio_pkg::OFS_DIN_MAP, '1, 32'h1, "din_map2");
    report_and_stop();
  end
endmodule
